// ===== core/osc_mode_reset_sequencer.v
// Purpose: oscillator mode decode, sleep control, power-up time-outs, reset causes
// Assumes: all inputs synchronous to clock_i; osc_tick_i pulses once per osc period
// Notes:   one design file; registers on Avalon-MM with waitrequest
//          reads take one wait state so the returned word comes from a flip-flop
//          the power-up timer runs for millions of cycles; ctrl bit0 skips it
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "osc_seq_consts.vh"

module osc_mode_reset_sequencer (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire [2:0]  osc_select_i,
  input  wire        powerup_timer_enable_n_i,
  input  wire        power_on_i,
  input  wire        brownout_i,
  input  wire        master_clear_pin_i,
  input  wire        watchdog_expire_i,
  input  wire        reset_instr_i,
  input  wire        stack_full_i,
  input  wire        stack_under_i,
  input  wire        sleep_instr_i,
  input  wire        interrupt_i,
  input  wire        high_priority_global_enable_i,
  input  wire        low_priority_global_enable_i,
  input  wire        high_priority_irq_i,
  input  wire        osc_switch_i,
  input  wire        osc_tick_i,
  input  wire [20:0] pc_i,
  input  wire        port_a6_pin_i,
  input  wire        port_a6_latch_i,
  input  wire        port_a6_dir_i,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [2:0]  osc_mode_o,
  output wire        core_reset_o,
  output wire        clocks_stopped_o,
  output wire        hold_first_quarter_o,
  output wire        osc_feedback_en_o,
  output wire        osc_output_low_o,
  output wire        pll_enable_o,
  output wire        port_a6_enable_o,
  output wire        port_a6_pin_o,
  output wire        port_a6_latch_o,
  output wire        port_a6_dir_o,
  output reg         pc_load_o,
  output reg  [20:0] pc_value_o,
  output reg         stack_push_o,
  output reg  [20:0] stack_top_o,
  output reg         stack_overflow_flag_o,
  output reg         stack_underflow_flag_o
);

  localparam [31:0] POWERUP_TIMER_CNT = `POWERUP_TIMER_CYCLES;
  localparam [31:0] PLL_CNT  = `PLL_CYCLES;
  localparam [31:0] OST_CNT  = `OST_PERIODS;

  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_POWERUP_TIMER  = 3'h1;
  localparam [2:0] ST_OST   = 3'h2;
  localparam [2:0] ST_PLL   = 3'h3;
  localparam [2:0] ST_SLEEP = 3'h4;

  // mode class decode, shared by many terms
  function is_crystal;
    input [2:0] m;
    begin
      is_crystal = (m == `MODE_LP) || (m == `MODE_XT) ||
                   (m == `MODE_HS) || (m == `MODE_HSPLL);
    end
  endfunction

  function is_io_mode;
    input [2:0] m;
    begin
      is_io_mode = (m == `MODE_RESISTOR_CAPACITOR_IO_MODE) || (m == `MODE_EXTERNAL_CLOCK_IO_MODE);
    end
  endfunction

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [31:0] count_r;
  reg  [31:0] count_nxt;
  reg  [7:0]  cause_r;
  reg         powerup_timer_disable_r;
  reg         wake_pending_r;
  reg  [20:0] resume_pc_r;
  reg         por_seen_r;
  reg         rd_done_r;
  reg         push_pending_r;

  wire crystal  = is_crystal(osc_mode_o);
  wire io_mode  = is_io_mode(osc_mode_o);
  wire pll_mode = (osc_mode_o == `MODE_HSPLL);
  wire powerup_timer_on  = ~powerup_timer_enable_n_i & ~powerup_timer_disable_r;
  wire sleeping = (state_r == ST_SLEEP);
  wire pwr_evt  = power_on_i | brownout_i;
  wire irq_vec  = high_priority_global_enable_i | low_priority_global_enable_i;
  // a power event or switch reloads the mode at this edge: stage on the new choice
  wire sel_crystal = is_crystal(osc_select_i);
  wire sel_pll     = (osc_select_i == `MODE_HSPLL);
  wire rd_take     = avs_read & ~rd_done_r;
  wire resume_now  = wake_pending_r && (state_r == ST_RUN);

  // first read cycle registers the word, the second hands it over
  assign avs_waitrequest = rd_take;

  // terminal count of a time-out stage
  function stage_end;
    input [31:0] cnt;
    input [31:0] limit;
    begin
      stage_end = (cnt >= limit - 32'h1);
    end
  endfunction

  // first stage after a power event, entered strictly in order
  function [2:0] first_stage;
    input pw;
    input xtal;
    input pll;
    begin
      if (pw)
        first_stage = ST_POWERUP_TIMER;
      else if (xtal)
        first_stage = ST_OST;
      else if (pll)
        first_stage = ST_PLL;
      else
        first_stage = ST_RUN;
    end
  endfunction

  always @* begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      ST_RUN: begin
        if (pwr_evt) begin
          state_nxt = first_stage(powerup_timer_on, sel_crystal, sel_pll);
          count_nxt = 32'h0;
        end else if (osc_switch_i && sel_crystal) begin
          state_nxt = ST_OST;
          count_nxt = 32'h0;
        end else if (sleep_instr_i) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_POWERUP_TIMER: begin
        count_nxt = count_r + 32'h1;
        if (stage_end(count_r, POWERUP_TIMER_CNT)) begin
          state_nxt = first_stage(1'b0, crystal, pll_mode);
          count_nxt = 32'h0;
        end
      end
      ST_OST: begin
        if (osc_tick_i)
          count_nxt = count_r + 32'h1;
        if (osc_tick_i && stage_end(count_r, OST_CNT)) begin
          state_nxt = pll_mode ? ST_PLL : ST_RUN;
          count_nxt = 32'h0;
        end
      end
      ST_PLL: begin
        count_nxt = count_r + 32'h1;
        if (stage_end(count_r, PLL_CNT)) begin
          state_nxt = ST_RUN;
          count_nxt = 32'h0;
        end
      end
      ST_SLEEP: begin
        if (pwr_evt) begin
          state_nxt = first_stage(powerup_timer_on, crystal, pll_mode);
          count_nxt = 32'h0;
        end else if (master_clear_pin_i || watchdog_expire_i || interrupt_i) begin
          state_nxt = crystal ? ST_OST : ST_RUN;
          count_nxt = 32'h0;
        end
      end
      default: begin
        state_nxt = ST_RUN;
        count_nxt = 32'h0;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
      count_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // mode is caught at reset release, and on an oscillator switch or power event while running
  always @(posedge clock_i) begin
    if (rst_i)
      osc_mode_o <= `MODE_LP;
    else if (state_r == ST_RUN && (osc_switch_i || pwr_evt) || por_seen_r == 1'b0)
      osc_mode_o <= osc_select_i;
  end

  always @(posedge clock_i) begin
    if (rst_i)
      por_seen_r <= 1'b0;
    else
      por_seen_r <= 1'b1;
  end

  // cause flags, program counter and stack actions
  always @(posedge clock_i) begin
    if (rst_i) begin
      cause_r                <= `CAUSE_RESET;
      pc_load_o              <= 1'b0;
      pc_value_o             <= `RESET_VECTOR;
      stack_push_o           <= 1'b0;
      stack_top_o            <= 21'h0;
      stack_overflow_flag_o  <= 1'b0;
      stack_underflow_flag_o <= 1'b0;
      wake_pending_r         <= 1'b0;
      resume_pc_r            <= 21'h0;
      powerup_timer_disable_r         <= 1'b0;
      push_pending_r         <= 1'b0;
    end else begin
      pc_load_o    <= 1'b0;
      stack_push_o <= 1'b0;
      // resume only once the wake-up time-out has run out; a later event overrides
      if (resume_now) begin
        wake_pending_r <= 1'b0;
        pc_load_o      <= 1'b1;
        pc_value_o     <= resume_pc_r;
        stack_push_o   <= push_pending_r;
        push_pending_r <= 1'b0;
      end
      // power-event and all sleep wake vectors (mclr, watchdog, interrupt) wait for the time-out too; the awake branches below load at once
      if (power_on_i) begin
        cause_r[4:0]   <= 5'h1C;
        wake_pending_r <= 1'b1;
        resume_pc_r    <= `RESET_VECTOR;
      end else if (brownout_i) begin
        cause_r[4:0]   <= {3'h7, cause_r[`CAUSE_POR], 1'b0};
        wake_pending_r <= 1'b1;
        resume_pc_r    <= `RESET_VECTOR;
      end else if (sleeping && master_clear_pin_i) begin
        cause_r[`CAUSE_TO] <= 1'b1;
        cause_r[`CAUSE_PD] <= 1'b0;
        wake_pending_r     <= 1'b1;
        resume_pc_r        <= `RESET_VECTOR;
      end else if (sleeping && watchdog_expire_i) begin
        cause_r[`CAUSE_TO] <= 1'b0;
        cause_r[`CAUSE_PD] <= 1'b0;
        wake_pending_r <= 1'b1;
        resume_pc_r    <= pc_i + 21'h2;
      end else if (sleeping && interrupt_i) begin
        cause_r[`CAUSE_TO] <= 1'b1;
        cause_r[`CAUSE_PD] <= 1'b0;
        wake_pending_r <= 1'b1;
        if (irq_vec) begin
          push_pending_r <= 1'b1;
          stack_top_o    <= pc_i;
          resume_pc_r  <= high_priority_irq_i ? `HIGH_VECTOR : `LOW_VECTOR;
        end else begin
          resume_pc_r  <= pc_i + 21'h2;
        end
      end else if (!sleeping && watchdog_expire_i) begin
        cause_r[`CAUSE_TO] <= 1'b0;
        cause_r[`CAUSE_PD] <= 1'b1;
        pc_load_o  <= 1'b1;
        pc_value_o <= `RESET_VECTOR;
      end else if (reset_instr_i) begin
        cause_r[`CAUSE_RI] <= 1'b0;
        pc_load_o  <= 1'b1;
        pc_value_o <= `RESET_VECTOR;
      end else if (stack_full_i || stack_under_i) begin
        if (stack_full_i)
          stack_overflow_flag_o <= 1'b1;
        if (stack_under_i)
          stack_underflow_flag_o <= 1'b1;
        pc_load_o  <= 1'b1;
        pc_value_o <= `RESET_VECTOR;
      end else if (master_clear_pin_i) begin
        pc_load_o  <= 1'b1;
        pc_value_o <= `RESET_VECTOR;
      end else if (avs_write && avs_address == `ADDR_CAUSE) begin
        // to and pd are read-only; software may only write bit 7, ri, por and bor
        cause_r[`CAUSE_PRIORITY_LEVELS_ENABLE] <= avs_writedata[`CAUSE_PRIORITY_LEVELS_ENABLE];
        cause_r[`CAUSE_RI]   <= avs_writedata[`CAUSE_RI];
        cause_r[`CAUSE_POR]  <= avs_writedata[`CAUSE_POR];
        cause_r[`CAUSE_BOR]  <= avs_writedata[`CAUSE_BOR];
      end else if (avs_write && avs_address == `ADDR_CTRL) begin
        powerup_timer_disable_r <= avs_writedata[0];
      end
      cause_r[6:5] <= 2'h0;
    end
  end

  // internal reset held through every time-out stage
  assign core_reset_o = (state_r == ST_POWERUP_TIMER) || (state_r == ST_OST) ||
                        (state_r == ST_PLL);
  assign clocks_stopped_o     = sleeping;
  assign hold_first_quarter_o = sleeping;
  assign osc_feedback_en_o    = ~(sleeping & crystal);
  // io modes hand the pin to port a in sleep and run alike
  assign osc_output_low_o     = sleeping & ~crystal & ~io_mode;
  assign pll_enable_o         = pll_mode;
  assign port_a6_enable_o     = io_mode;

  // pin, latch and direction views of the bit are gated alike
  wire [2:0] pa6_in = {port_a6_pin_i, port_a6_latch_i, port_a6_dir_i};
  wire [2:0] pa6_out;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pa6
      assign pa6_out[g] = io_mode & pa6_in[g];
    end
  endgenerate
  assign port_a6_pin_o        = pa6_out[2];
  assign port_a6_latch_o      = pa6_out[1];
  assign port_a6_dir_o        = pa6_out[0];

  // word registered in the waited cycle, held while waitrequest is low
  always @(posedge clock_i) begin
    if (rst_i) begin
      avs_readdata <= 32'h0;
      rd_done_r    <= 1'b0;
    end else begin
      rd_done_r <= rd_take;
      if (rd_take) begin
        case (avs_address)
          `ADDR_CAUSE: avs_readdata <= {24'h0, cause_r[7], 2'h0, cause_r[4:0]};
          `ADDR_CTRL:  avs_readdata <= {31'h0, powerup_timer_disable_r};
          `ADDR_SEQ:   avs_readdata <= {24'h0, io_mode, crystal, osc_mode_o, state_r};
          `ADDR_PC:    avs_readdata <= {11'h0, pc_value_o};
          default:     avs_readdata <= 32'h0;
        endcase
      end
    end
  end

endmodule // osc_mode_reset_sequencer

// ===== pkg/osc_seq_consts.vh
// Purpose: constants for the oscillator mode and reset sequencer
// Assumes: 200 MHz system clock, 5 ns period
// Notes:   offsets are word byte addresses on the register bus
`ifndef OSC_SEQ_CONSTS_VH
`define OSC_SEQ_CONSTS_VH

`define CLK_PERIOD_PS       5000
`define POWERUP_TIMER_DELAY_MS       72
`define PLL_LOCK_MS         2
// cycles per millisecond first, so no 32-bit product overflows
`define CYCLES_PER_MS       (1000000000 / `CLK_PERIOD_PS)
`define POWERUP_TIMER_CYCLES         (`POWERUP_TIMER_DELAY_MS * `CYCLES_PER_MS)
`define PLL_CYCLES          (`PLL_LOCK_MS * `CYCLES_PER_MS)
`define OST_PERIODS         1024

`define MODE_LP             3'h0
`define MODE_XT             3'h1
`define MODE_HS             3'h2
`define MODE_HSPLL          3'h3
`define MODE_RC             3'h4
`define MODE_RESISTOR_CAPACITOR_IO_MODE           3'h5
`define MODE_EC             3'h6
`define MODE_EXTERNAL_CLOCK_IO_MODE           3'h7

`define ADDR_CAUSE          4'h0
`define ADDR_CTRL           4'h4
`define ADDR_SEQ            4'h8
`define ADDR_PC             4'hC

`define CAUSE_PRIORITY_LEVELS_ENABLE          7
`define CAUSE_RI            4
`define CAUSE_TO            3
`define CAUSE_PD            2
`define CAUSE_POR           1
`define CAUSE_BOR           0
`define CAUSE_RESET         8'h1C

`define RESET_VECTOR        21'h000000
`define HIGH_VECTOR         21'h000008
`define LOW_VECTOR          21'h000018

`endif

// ===== sim/osc_seq_assertions.sv
// Purpose: port checks for the sequencer
// Assumes: one clock, sync reset
// Notes:   bound to the design top
`timescale 1ns/10ps
module osc_seq_checker (
  input wire       clock_i,
  input wire       rst_i,
  input wire [2:0] osc_mode_o,
  input wire       clocks_stopped_o,
  input wire       hold_first_quarter_o,
  input wire       osc_feedback_en_o,
  input wire       osc_output_low_o,
  input wire       pll_enable_o,
  input wire       port_a6_enable_o,
  input wire       port_a6_pin_o,
  input wire       pc_load_o,
  input wire       core_reset_o,
  input wire       stack_push_o,
  input wire       stack_overflow_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire io_m = osc_mode_o[2] & osc_mode_o[0];
  wire rc_m = osc_mode_o[2] & ~osc_mode_o[0];
  a_sleep_quarter: assert property (clocks_stopped_o == hold_first_quarter_o)
    else $error("quarter hold wrong");
  a_pll_mode: assert property (pll_enable_o == (osc_mode_o == 3'h3))
    else $error("pll enable wrong");
  a_port_a_pins_gate: assert property (!io_m |-> !port_a6_enable_o && !port_a6_pin_o)
    else $error("port bit not gated");
  a_osc_low: assert property (osc_output_low_o == (clocks_stopped_o && rc_m))
    else $error("osc output level wrong");
  a_feedback_off: assert property (osc_feedback_en_o == !(clocks_stopped_o && !osc_mode_o[2]))
    else $error("feedback enable wrong");
  a_push_load: assert property (stack_push_o |-> ##[0:1] pc_load_o)
    else $error("push without vector load");
  a_load_run: assert property (pc_load_o |-> !core_reset_o && !clocks_stopped_o)
    else $error("pc load while held");
  a_stack_sticky: assert property (stack_overflow_flag_o |=> stack_overflow_flag_o)
    else $error("stack flag dropped");
endmodule // osc_seq_checker
bind osc_mode_reset_sequencer osc_seq_checker chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .osc_mode_o(osc_mode_o),
  .clocks_stopped_o(clocks_stopped_o), .hold_first_quarter_o(hold_first_quarter_o),
  .osc_feedback_en_o(osc_feedback_en_o), .osc_output_low_o(osc_output_low_o),
  .pll_enable_o(pll_enable_o), .port_a6_enable_o(port_a6_enable_o),
  .port_a6_pin_o(port_a6_pin_o), .pc_load_o(pc_load_o), .core_reset_o(core_reset_o),
  .stack_push_o(stack_push_o), .stack_overflow_flag_o(stack_overflow_flag_o)
);

// ===== sim/osc_source.sv
// Purpose: crystal or clock source feeding oscillator periods
// Assumes: one period every DIV system cycles
// Notes:   stands still while the device sleeps
`timescale 1ns/10ps
module osc_source #(parameter int DIV = 2) (
  input  wire  clock_i,
  input  wire  run_i,
  output logic tick_o
);
  int cnt = 0;
  initial tick_o = 1'b0;
  always @(posedge clock_i) begin
    cnt <= (run_i && cnt < DIV - 1) ? cnt + 1 : 0;
    tick_o <= run_i && cnt == DIV - 1;
  end
endmodule // osc_source

// ===== sim/osc_mode_reset_sequencer_tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: power-up timer disabled, osc period two cycles
// Notes:   pll wake paths run too long and are skipped
`timescale 1ns/10ps
module osc_mode_reset_sequencer_tb;
  logic        clock_i = 0, rst_i = 1, powerup_timer_enable_n_i = 1;
  logic        high_priority_global_enable_i = 0, low_priority_global_enable_i = 0;
  logic        high_priority_irq_i = 0, port_a6_pin_i = 0, port_a6_latch_i = 0;
  logic        port_a6_dir_i = 0, avs_read = 0, avs_write = 0;
  logic [2:0]  osc_select_i = 0;
  logic [20:0] pc_i = 0;
  logic [3:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [9:0]  ev = 0;
  wire         power_on_i, brownout_i, master_clear_pin_i, watchdog_expire_i, reset_instr_i;
  wire         stack_full_i, stack_under_i, sleep_instr_i, interrupt_i, osc_switch_i;
  wire         osc_tick_i, avs_waitrequest, core_reset_o, clocks_stopped_o, pll_enable_o;
  wire         hold_first_quarter_o, osc_feedback_en_o, osc_output_low_o, port_a6_enable_o;
  wire         port_a6_pin_o, port_a6_latch_o, port_a6_dir_o, pc_load_o, stack_push_o;
  wire         stack_overflow_flag_o, stack_underflow_flag_o;
  wire [31:0]  avs_readdata;
  wire [2:0]   osc_mode_o;
  wire [20:0]  pc_value_o, stack_top_o;
  wire [3:0]   pa_in = {port_a6_pin_i, port_a6_latch_i, port_a6_dir_i, 1'b1};
  wire [3:0]   pa_out = {port_a6_pin_o, port_a6_latch_o, port_a6_dir_o, port_a6_enable_o};
  int          failures = 0, total_checks = 0, loads = 0, pushes = 0, osc_startup_timer = 0, cyc = 0;
  logic [20:0] got_pc;
  logic [7:0]  cm;
  logic [31:0] rd_q = 0;
  assign {osc_switch_i, interrupt_i, sleep_instr_i, stack_under_i, stack_full_i,
          reset_instr_i, watchdog_expire_i, master_clear_pin_i, brownout_i, power_on_i} = ev;
  osc_mode_reset_sequencer dut (
    .clock_i(clock_i), .rst_i(rst_i), .osc_select_i(osc_select_i),
    .powerup_timer_enable_n_i(powerup_timer_enable_n_i), .power_on_i(power_on_i),
    .brownout_i(brownout_i), .master_clear_pin_i(master_clear_pin_i),
    .watchdog_expire_i(watchdog_expire_i), .reset_instr_i(reset_instr_i),
    .stack_full_i(stack_full_i), .stack_under_i(stack_under_i),
    .sleep_instr_i(sleep_instr_i), .interrupt_i(interrupt_i),
    .high_priority_global_enable_i(high_priority_global_enable_i),
    .low_priority_global_enable_i(low_priority_global_enable_i),
    .high_priority_irq_i(high_priority_irq_i), .osc_switch_i(osc_switch_i),
    .osc_tick_i(osc_tick_i), .pc_i(pc_i), .port_a6_pin_i(port_a6_pin_i),
    .port_a6_latch_i(port_a6_latch_i), .port_a6_dir_i(port_a6_dir_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_mode_o(osc_mode_o),
    .core_reset_o(core_reset_o), .clocks_stopped_o(clocks_stopped_o),
    .hold_first_quarter_o(hold_first_quarter_o), .osc_feedback_en_o(osc_feedback_en_o),
    .osc_output_low_o(osc_output_low_o), .pll_enable_o(pll_enable_o),
    .port_a6_enable_o(port_a6_enable_o), .port_a6_pin_o(port_a6_pin_o),
    .port_a6_latch_o(port_a6_latch_o), .port_a6_dir_o(port_a6_dir_o),
    .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .stack_push_o(stack_push_o),
    .stack_top_o(stack_top_o), .stack_overflow_flag_o(stack_overflow_flag_o),
    .stack_underflow_flag_o(stack_underflow_flag_o)
  );
  osc_source #(.DIV(2)) xtal (.clock_i(clock_i), .run_i(!clocks_stopped_o), .tick_o(osc_tick_i));
  always #2.5 clock_i = !clock_i;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (pc_load_o === 1'b1) begin
      loads <= loads + 1;
      got_pc <= pc_value_o;
    end
    if (stack_push_o === 1'b1) pushes <= pushes + 1;
    if (core_reset_o === 1'b1 && osc_tick_i === 1'b1) osc_startup_timer <= osc_startup_timer + 1;
    if (cyc == 30000) begin
      failures++;
      summarize;
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clock_i);
    ev <= 10'h1 << i;
    @(posedge clock_i);
    ev <= 10'h0;
  endtask
  // request held until waitrequest is seen low; read data taken at that same edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clock_i);
    while (avs_waitrequest !== 1'b0) @(posedge clock_i);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic reg_chk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("reg", e, rd_q);
  endtask
  task automatic ev_pc(input int i, input logic [20:0] e);
    int n;
    n = loads;
    pulse(i);
    repeat (4000) if (loads == n) @(posedge clock_i);
    chk("pc", e, got_pc);
  endtask
  task automatic sleep_now;
    pulse(7);
    repeat (20) if (clocks_stopped_o !== 1'b1) @(posedge clock_i);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    int n;
    void'($urandom(32'h6254EE83));
    for (int m = 0; m < 8; m++) begin
      @(posedge clock_i);
      rst_i <= 1'b1;
      osc_select_i <= 3'(m);
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      pc_i <= 21'($urandom);
      {port_a6_pin_i, port_a6_latch_i, port_a6_dir_i} <= 3'($urandom);
      repeat (2) @(posedge clock_i);
      chk("mode", m, osc_mode_o);
      chk("pll", m == 3, pll_enable_o);
      chk("pa6", (m == 5 || m == 7) ? pa_in : 4'h0, pa_out);
      reg_chk(4'h0, 32'h1C);
      if (m != 3) begin
        sleep_now;
        chk("stop", 2'b11, {clocks_stopped_o, hold_first_quarter_o});
        chk("fb", m > 3, osc_feedback_en_o);
        chk("olow", m == 4 || m == 6, osc_output_low_o);
        n = osc_startup_timer;
        ev_pc(8, pc_i + 21'h2);
        chk("ost", 1, m < 3 ? (osc_startup_timer - n) inside {1024, 1025} : osc_startup_timer == n);
        reg_chk(4'h0, 32'h18);
        n = osc_startup_timer;
        pulse(9);
        repeat (2) @(posedge clock_i);
        repeat (3000) if (core_reset_o === 1'b1) @(posedge clock_i);
        chk("switch", 1, m < 3 ? (osc_startup_timer - n) inside {1024, 1025} : osc_startup_timer == n);
      end
    end
    cm = 8'h18;
    sleep_now;
    ev_pc(3, pc_i + 21'h2);
    cm[3:2] = 2'b00;
    reg_chk(4'h0, cm);
    sleep_now;
    ev_pc(2, 21'h0);
    cm[3:2] = 2'b10;
    reg_chk(4'h0, cm);
    for (int k = 0; k < 2; k++) begin
      high_priority_global_enable_i <= k == 0;
      low_priority_global_enable_i <= k == 1;
      high_priority_irq_i <= k == 0;
      pc_i <= 21'($urandom);
      sleep_now;
      n = pushes;
      ev_pc(8, k == 0 ? 21'h8 : 21'h18);
      @(posedge clock_i);
      chk("push", n + 1, pushes);
      chk("top", pc_i, stack_top_o);
    end
    high_priority_global_enable_i <= 1'b0;
    low_priority_global_enable_i <= 1'b0;
    ev_pc(3, 21'h0);
    cm[3:2] = 2'b01;
    reg_chk(4'h0, cm);
    ev_pc(2, 21'h0);
    reg_chk(4'h0, cm);
    ev_pc(4, 21'h0);
    cm[4] = 1'b0;
    reg_chk(4'h0, cm);
    ev_pc(5, 21'h0);
    chk("stk", 2'b10, {stack_overflow_flag_o, stack_underflow_flag_o});
    ev_pc(6, 21'h0);
    chk("stk", 2'b11, {stack_overflow_flag_o, stack_underflow_flag_o});
    reg_chk(4'h0, cm);
    bus(1'b1, 4'h0, 32'hFF);
    cm = {3'b100, 1'b1, cm[3:2], 2'b11};
    reg_chk(4'h0, cm);
    bus(1'b1, 4'h0, 32'h13);
    cm[7] = 1'b0;
    reg_chk(4'h0, cm);
    bus(1'b1, 4'h4, 32'h1);
    reg_chk(4'h4, 32'h1);
    reg_chk(4'h2, 32'h0);
    ev_pc(1, 21'h0);
    cm = {cm[7:5], 3'b111, cm[1], 1'b0};
    reg_chk(4'h0, cm);
    ev_pc(0, 21'h0);
    reg_chk(4'h0, 32'h1C);
    summarize;
  end
endmodule // osc_mode_reset_sequencer_tb
